/* File: opd_pkg.sv */
// opcode decode and timing package: opcodes, field layouts, clock counts
// assumes one processor clock per count; used by the decoder and its timer
//
// Contract
// - load segment register, 2 or 9 clocks
// - copy segment register out, 2 or 11
// - table translate byte, 11 clocks
// - load operand address, 6 clocks
// - far pointer loads, 18 clocks, memory only
// - flags to high acc 2, back 3
// - ascii adjust 8, decimal adjust 4 clocks
// - multiply adjust 19, divide adjust 15
// - byte extend 2, word extend 4
// - unsigned divide 29/38/35/44 clocks
// - signed quotient ranges per operand kind
// - immediate multiply, byte or word immediate
// - shift kind field selects operation
// - test and, flags only, 3 or 10
// - addressing form selects displacement length
// - address calculation 4 clocks, included
// - register field maps word or byte
`default_nettype none
package opd_pkg;
    localparam logic [7:0] OP_SEG_LOAD = 8'h8E;
    localparam logic [7:0] OP_SEG_STORE = 8'h8C;
    localparam logic [7:0] OP_XLATE = 8'hD7;
    localparam logic [7:0] OP_LOAD_ADDR = 8'h8D;
    localparam logic [7:0] OP_FAR_DATA = 8'hC5;
    localparam logic [7:0] OP_FAR_EXTRA = 8'hC4;
    localparam logic [7:0] OP_FLAGS_TO_ACC = 8'h9F;
    localparam logic [7:0] OP_ACC_TO_FLAGS = 8'h9E;
    localparam logic [7:0] OP_ADJ_ADD = 8'h37;
    localparam logic [7:0] OP_DEC_ADD = 8'h27;
    localparam logic [7:0] OP_ADJ_MUL = 8'hD4;
    localparam logic [7:0] OP_ADJ_DIV = 8'hD5;
    localparam logic [7:0] ADJ_BASE = 8'h0A;
    localparam logic [7:0] OP_BYTE_EXT = 8'h98;
    localparam logic [7:0] OP_WORD_EXT = 8'h99;
    localparam logic [6:0] OP_GRP_ARITH = 7'h7B;
    localparam logic [5:0] OP_IMM_MUL = 6'h1A;
    localparam logic [6:0] OP_TEST_RM = 7'h42;
    localparam logic [6:0] OP_PORT_IN = 7'h36;
    localparam logic [6:0] OP_PORT_OUT = 7'h37;
    localparam logic [6:0] OP_STR_LOAD = 7'h56;
    localparam logic [6:0] OP_STR_STORE = 7'h55;
    localparam logic [5:0] OP_SHIFT_GRP = 6'h34;
    localparam logic [6:0] OP_SHIFT_IMM = 7'h60;
    localparam logic [2:0] GRP_MUL_S = 3'h5;
    localparam logic [2:0] GRP_DIV_U = 3'h6;
    localparam logic [2:0] GRP_DIV_S = 3'h7;
    localparam logic [1:0] FORM_REG = 2'h3;
    localparam logic [1:0] FORM_DISP8 = 2'h1;
    localparam logic [1:0] FORM_DISP16 = 2'h2;
    localparam logic [2:0] RM_DIRECT = 3'h6;
    localparam int MOD_POS = 6;
    localparam int REG_POS = 3;
    localparam logic [7:0] ADDR_CLKS = 8'h04;
    localparam logic [7:0] SEG_LOAD_CLKS_R = 8'h02;
    localparam logic [7:0] SEG_LOAD_CLKS_M = 8'h09;
    localparam logic [7:0] SEG_STORE_CLKS_R = 8'h02;
    localparam logic [7:0] SEG_STORE_CLKS_M = 8'h0B;
    localparam logic [7:0] XLATE_CLKS = 8'h0B;
    localparam logic [7:0] LOAD_ADDR_CLKS = 8'h06;
    localparam logic [7:0] FAR_CLKS = 8'h12;
    localparam logic [7:0] FLAGS_TO_ACC_CLKS = 8'h02;
    localparam logic [7:0] ACC_TO_FLAGS_CLKS = 8'h03;
    localparam logic [7:0] ADJ_ADD_CLKS = 8'h08;
    localparam logic [7:0] DEC_ADD_CLKS = 8'h04;
    localparam logic [7:0] ADJ_MUL_CLKS = 8'h13;
    localparam logic [7:0] ADJ_DIV_CLKS = 8'h0F;
    localparam logic [7:0] BYTE_EXT_CLKS = 8'h02;
    localparam logic [7:0] WORD_EXT_CLKS = 8'h04;
    localparam logic [7:0] DIVU_RB = 8'h1D;
    localparam logic [7:0] DIVU_RW = 8'h26;
    localparam logic [7:0] DIVU_MB = 8'h23;
    localparam logic [7:0] DIVU_MW = 8'h2C;
    localparam logic [7:0] DIVS_RB = 8'h2C;
    localparam logic [7:0] DIVS_RW = 8'h35;
    localparam logic [7:0] DIVS_MB = 8'h32;
    localparam logic [7:0] DIVS_MW = 8'h3B;
    localparam logic [7:0] DIVS_SPAN = 8'h08;
    localparam logic [7:0] MULS_RB = 8'h19;
    localparam logic [7:0] MULS_RW = 8'h22;
    localparam logic [7:0] MULS_MB = 8'h1F;
    localparam logic [7:0] MULS_MW = 8'h28;
    localparam logic [7:0] MULS_SPAN = 8'h03;
    localparam logic [7:0] SIGNED_PRODUCT_R = 8'h16;
    localparam logic [7:0] SIGNED_PRODUCT_M = 8'h1D;
    localparam logic [7:0] SIGNED_PRODUCT_SPAN = 8'h03;
    localparam logic [7:0] TEST_CLKS_R = 8'h03;
    localparam logic [7:0] TEST_CLKS_M = 8'h0A;
    localparam logic [7:0] PORT_STR_CLKS = 8'h0E;
    localparam logic [7:0] STR_LOAD_CLKS = 8'h0C;
    localparam logic [7:0] STR_STORE_CLKS = 8'h0A;
    localparam logic [7:0] SHIFT1_R = 8'h02;
    localparam logic [7:0] SHIFT1_M = 8'h0F;
    localparam logic [7:0] SHIFTN_R = 8'h05;
    localparam logic [7:0] SHIFTN_M = 8'h11;

    typedef enum logic [4:0] {
        OPD_NONE, OPD_SEG_LOAD, OPD_SEG_STORE, OPD_XLATE, OPD_LOAD_ADDR,
        OPD_FAR_DATA, OPD_FAR_EXTRA, OPD_FLAGS_TO_ACC, OPD_ACC_TO_FLAGS,
        OPD_ADJ_ADD, OPD_DEC_ADD, OPD_ADJ_MUL, OPD_ADJ_DIV, OPD_BYTE_EXT,
        OPD_WORD_EXT, OPD_DIV_U, OPD_DIV_S, OPD_MUL_S, OPD_IMM_MUL,
        OPD_SHIFT, OPD_TEST, OPD_PORT_IN, OPD_PORT_OUT, OPD_STR_LOAD,
        OPD_STR_STORE, OPD_ILLEGAL
    } opd_op_t;

    typedef enum logic [2:0] {
        SK_ROTATE_LEFT, SK_ROTATE_RIGHT, SK_ROTATE_LEFT_CARRY,
        SK_ROTATE_RIGHT_CARRY, SK_SHIFT_LEFT, SK_LOGICAL_SHIFT_RIGHT,
        SK_RESERVED, SK_ARITHMETIC_SHIFT_RIGHT
    } opd_shift_t;

    // one fully decoded instruction, as presented at the outputs
    typedef struct packed {
        opd_op_t op;
        opd_shift_t shift_kind_field;
        logic is_word;
        logic mem_operand;
        logic [2:0] reg_sel;
        logic [2:0] rm_sel;
        logic [1:0] disp_bytes;
        logic [1:0] imm_bytes;
        logic [7:0] clk_min;
        logic [7:0] clk_max;
    } opd_decode_t;
endpackage : opd_pkg
`default_nettype wire

/* File: opd_timer.sv */
// execution clock counter for one decoded instruction
// assumes start arrives only while idle; same clock domain as the decoder
`default_nettype none
`timescale 1ns/10ps
module opd_timer (
    input wire logic clk, // processor clock
    input wire logic nrst, // async reset, active low
    input wire logic en, // clock enable
    input wire logic start, // load a new count
    input wire logic [7:0] cycles, // clocks the instruction takes
    output logic busy, // counting down
    output logic done // last clock of the instruction
);
    import opd_pkg::*;
    logic [7:0] remain;
    logic [7:0] next_remain;
    logic next_busy;
    logic next_done;

    // count down; done marks the final execution clock
    always_comb begin
        next_remain = remain;
        next_busy = busy;
        next_done = 1'b0;
        if (start) begin
            next_remain = cycles;
            next_busy = (cycles != 8'h01);
            next_done = (cycles == 8'h01);
        end else if (busy) begin
            next_remain = remain - 8'h01;
            next_done = (remain == 8'h02);
            next_busy = (remain != 8'h02);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            remain <= 8'h00;
            busy <= 1'b0;
            done <= 1'b0;
        end else if (en) begin
            remain <= next_remain;
            busy <= next_busy;
            done <= next_done;
        end
    end
endmodule : opd_timer
`default_nettype wire

/* File: opd_decode.sv */
// opcode decoder with execution timing for the 16-bit core
// assumes bytes arrive from the prefetch queue on clk with a valid strobe
`default_nettype none
`timescale 1ns/10ps
module opd_decode (
    input wire logic clk, // processor clock
    input wire logic nrst, // async reset, active low
    input wire logic en, // clock enable, freezes all state
    input wire logic byte_valid, // queue byte present
    input wire logic [7:0] byte_data, // queue byte
    input wire logic [7:0] count_register_low, // shift count source
    input wire logic data_mem_slow, // multiply/divide takes the long end
    output logic byte_take, // registered pulse: byte consumed in the previous cycle
    output opd_pkg::opd_decode_t dec, // decoded instruction
    output logic dec_valid, // pulse: dec newly valid
    output logic exec_busy, // instruction executing
    output logic exec_done, // registered pulse: clock after the last execution clock
    output logic [7:0] exec_clocks // clocks charged to the instruction
);
    import opd_pkg::*;

    typedef enum logic [2:0] {
        ST_OPCODE, ST_MODRM, ST_SECOND, ST_DISP, ST_IMM, ST_COUNT, ST_EXEC
    } opd_state_t;

    opd_state_t state;
    opd_state_t next_state;
    opd_decode_t cur;
    opd_decode_t next_cur;
    logic [1:0] left;
    logic [1:0] next_left;
    logic next_valid;
    logic next_take;
    logic [7:0] next_clocks;
    logic start;
    logic tmr_busy;
    logic tmr_done;
    logic by_cl;
    logic next_by_cl;

    // pick register or memory figure from a pair
    function automatic logic [7:0] pick(input logic mem, input logic [7:0] r,
                                        input logic [7:0] m);
        pick = mem ? m : r;
    endfunction : pick

    // classify the opcode byte; rest of the fields come later
    function automatic opd_op_t classify(input logic [7:0] b);
        classify = OPD_NONE;
        if (b == OP_SEG_LOAD) classify = OPD_SEG_LOAD;
        else if (b == OP_SEG_STORE) classify = OPD_SEG_STORE;
        else if (b == OP_XLATE) classify = OPD_XLATE;
        else if (b == OP_LOAD_ADDR) classify = OPD_LOAD_ADDR;
        else if (b == OP_FAR_DATA) classify = OPD_FAR_DATA;
        else if (b == OP_FAR_EXTRA) classify = OPD_FAR_EXTRA;
        else if (b == OP_FLAGS_TO_ACC) classify = OPD_FLAGS_TO_ACC;
        else if (b == OP_ACC_TO_FLAGS) classify = OPD_ACC_TO_FLAGS;
        else if (b == OP_ADJ_ADD) classify = OPD_ADJ_ADD;
        else if (b == OP_DEC_ADD) classify = OPD_DEC_ADD;
        else if (b == OP_ADJ_MUL) classify = OPD_ADJ_MUL;
        else if (b == OP_ADJ_DIV) classify = OPD_ADJ_DIV;
        else if (b == OP_BYTE_EXT) classify = OPD_BYTE_EXT;
        else if (b == OP_WORD_EXT) classify = OPD_WORD_EXT;
        else if (b[7:1] == OP_GRP_ARITH) classify = OPD_DIV_U; // refined by field
        else if (b[7:2] == OP_IMM_MUL && b[0]) classify = OPD_IMM_MUL;
        else if (b[7:2] == OP_SHIFT_GRP || b[7:1] == OP_SHIFT_IMM) classify = OPD_SHIFT;
        else if (b[7:1] == OP_TEST_RM) classify = OPD_TEST;
        else if (b[7:1] == OP_PORT_IN) classify = OPD_PORT_IN;
        else if (b[7:1] == OP_PORT_OUT) classify = OPD_PORT_OUT;
        else if (b[7:1] == OP_STR_LOAD) classify = OPD_STR_LOAD;
        else if (b[7:1] == OP_STR_STORE) classify = OPD_STR_STORE;
    endfunction : classify

    // byte count of displacement from addressing form
    function automatic logic [1:0] disp_len(input logic [7:0] m);
        disp_len = 2'h0;
        if (m[7:MOD_POS] == FORM_DISP8) disp_len = 2'h1;
        else if (m[7:MOD_POS] == FORM_DISP16) disp_len = 2'h2;
        else if (m[7:MOD_POS] == 2'h0 && m[2:0] == RM_DIRECT) disp_len = 2'h2;
    endfunction : disp_len

    // clock figures once addressing byte is known; address time is inside
    function automatic opd_decode_t timing(input opd_decode_t d);
        opd_decode_t t;
        logic mem;
        logic [7:0] lo;
        logic [7:0] span;
        t = d;
        mem = d.mem_operand;
        lo = 8'h00;
        span = 8'h00;
        unique case (d.op)
            OPD_SEG_LOAD: lo = pick(mem, SEG_LOAD_CLKS_R, SEG_LOAD_CLKS_M);
            OPD_SEG_STORE: lo = pick(mem, SEG_STORE_CLKS_R, SEG_STORE_CLKS_M);
            OPD_LOAD_ADDR: lo = LOAD_ADDR_CLKS;
            OPD_FAR_DATA, OPD_FAR_EXTRA: lo = FAR_CLKS;
            OPD_DIV_U: lo = d.is_word ? pick(mem, DIVU_RW, DIVU_MW)
                                      : pick(mem, DIVU_RB, DIVU_MB);
            OPD_DIV_S: begin
                lo = d.is_word ? pick(mem, DIVS_RW, DIVS_MW)
                               : pick(mem, DIVS_RB, DIVS_MB);
                span = DIVS_SPAN;
            end
            OPD_MUL_S: begin
                lo = d.is_word ? pick(mem, MULS_RW, MULS_MW)
                               : pick(mem, MULS_RB, MULS_MB);
                span = MULS_SPAN;
            end
            OPD_IMM_MUL: begin
                lo = pick(mem, SIGNED_PRODUCT_R, SIGNED_PRODUCT_M);
                span = SIGNED_PRODUCT_SPAN;
            end
            OPD_TEST: lo = pick(mem, TEST_CLKS_R, TEST_CLKS_M);
            OPD_SHIFT: lo = pick(mem, SHIFT1_R, SHIFT1_M);
            default: lo = d.clk_min;
        endcase
        t.clk_min = lo;
        t.clk_max = lo + span;
        timing = t;
    endfunction : timing

    // decode sequencer: opcode, addressing byte, extra bytes, then execute
    always_comb begin
        next_state = state;
        next_cur = cur;
        next_left = left;
        next_valid = 1'b0;
        next_take = 1'b0;
        start = 1'b0;
        next_clocks = exec_clocks;
        next_by_cl = by_cl;
        unique case (state)
            ST_OPCODE: if (byte_valid) begin
                next_take = 1'b1;
                next_cur = '0;
                next_cur.op = classify(byte_data);
                next_cur.is_word = byte_data[0];
                next_by_cl = byte_data[1];
                next_cur.clk_min = 8'h00;
                unique case (classify(byte_data))
                    OPD_XLATE: next_cur.clk_min = XLATE_CLKS;
                    OPD_FLAGS_TO_ACC: next_cur.clk_min = FLAGS_TO_ACC_CLKS;
                    OPD_ACC_TO_FLAGS: next_cur.clk_min = ACC_TO_FLAGS_CLKS;
                    OPD_ADJ_ADD: next_cur.clk_min = ADJ_ADD_CLKS;
                    OPD_DEC_ADD: next_cur.clk_min = DEC_ADD_CLKS;
                    OPD_ADJ_MUL: next_cur.clk_min = ADJ_MUL_CLKS;
                    OPD_ADJ_DIV: next_cur.clk_min = ADJ_DIV_CLKS;
                    OPD_BYTE_EXT: next_cur.clk_min = BYTE_EXT_CLKS;
                    OPD_WORD_EXT: next_cur.clk_min = WORD_EXT_CLKS;
                    OPD_PORT_IN, OPD_PORT_OUT: next_cur.clk_min = PORT_STR_CLKS;
                    OPD_STR_LOAD: next_cur.clk_min = STR_LOAD_CLKS;
                    OPD_STR_STORE: next_cur.clk_min = STR_STORE_CLKS;
                    OPD_IMM_MUL: next_cur.imm_bytes = byte_data[1] ? 2'h1 : 2'h2;
                    OPD_SHIFT: next_cur.imm_bytes = {1'b0, ~byte_data[4]};
                    default: ;
                endcase
                next_cur.clk_max = next_cur.clk_min;
                if (classify(byte_data) == OPD_NONE) begin
                    next_state = ST_OPCODE; // unknown bytes belong to other decoders
                end else if (classify(byte_data) == OPD_ADJ_MUL
                             || classify(byte_data) == OPD_ADJ_DIV) begin
                    next_state = ST_SECOND;
                end else if (next_cur.clk_min != 8'h00) begin
                    next_state = ST_EXEC;
                end else begin
                    next_state = ST_MODRM;
                end
            end
            ST_SECOND: if (byte_valid) begin
                next_take = 1'b1;
                if (byte_data != ADJ_BASE) next_cur.op = OPD_ILLEGAL;
                next_state = ST_EXEC;
            end
            ST_MODRM: if (byte_valid) begin
                next_take = 1'b1;
                next_cur.mem_operand = (byte_data[7:MOD_POS] != FORM_REG);
                next_cur.reg_sel = byte_data[5:REG_POS];
                next_cur.rm_sel = byte_data[2:0];
                next_cur.disp_bytes = disp_len(byte_data);
                next_cur.shift_kind_field = opd_shift_t'(byte_data[5:REG_POS]);
                if (cur.op == OPD_DIV_U) begin
                    unique case (byte_data[5:REG_POS])
                        GRP_DIV_U: next_cur.op = OPD_DIV_U;
                        GRP_DIV_S: next_cur.op = OPD_DIV_S;
                        GRP_MUL_S: next_cur.op = OPD_MUL_S;
                        default: next_cur.op = OPD_NONE;
                    endcase
                end
                if (cur.op == OPD_SHIFT && byte_data[5:REG_POS] == SK_RESERVED) begin
                    next_cur.op = OPD_ILLEGAL;
                end
                if ((cur.op == OPD_FAR_DATA || cur.op == OPD_FAR_EXTRA
                     || cur.op == OPD_LOAD_ADDR) && byte_data[7:MOD_POS] == FORM_REG) begin
                    next_cur.op = OPD_ILLEGAL;
                end
                next_cur = timing(next_cur);
                next_left = next_cur.disp_bytes;
                if (next_cur.disp_bytes != 2'h0) next_state = ST_DISP;
                else if (next_cur.imm_bytes != 2'h0) begin
                    next_left = next_cur.imm_bytes;
                    next_state = ST_IMM;
                end else next_state = ST_EXEC;
            end
            ST_DISP: if (byte_valid) begin
                next_take = 1'b1;
                next_left = left - 2'h1;
                if (left == 2'h1) begin
                    next_left = cur.imm_bytes;
                    next_state = (cur.imm_bytes != 2'h0) ? ST_IMM : ST_EXEC;
                end
            end
            ST_IMM: if (byte_valid) begin
                next_take = 1'b1;
                next_left = left - 2'h1;
                if (left == 2'h1) next_state = ST_EXEC;
            end
            ST_COUNT: if (!tmr_busy && !start) next_state = ST_OPCODE;
            ST_EXEC: begin
                next_valid = 1'b1;
                start = 1'b1;
                next_clocks = data_mem_slow ? cur.clk_max : cur.clk_min;
                if (cur.op == OPD_SHIFT && (by_cl || cur.imm_bytes != 2'h0)) begin
                    // per-bit cost; the count byte form is charged the same way
                    next_clocks = pick(cur.mem_operand, SHIFTN_R, SHIFTN_M)
                                  + count_register_low;
                end
                if (cur.op == OPD_ILLEGAL || cur.op == OPD_NONE) next_clocks = 8'h01;
                next_state = ST_COUNT;
            end
            default: next_state = ST_OPCODE;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_OPCODE;
            cur <= '0;
            left <= 2'h0;
            by_cl <= 1'b0;
            dec <= '0;
            dec_valid <= 1'b0;
            byte_take <= 1'b0;
            exec_clocks <= 8'h00;
        end else if (en) begin
            state <= next_state;
            cur <= next_cur;
            left <= next_left;
            by_cl <= next_by_cl;
            dec_valid <= next_valid;
            byte_take <= next_take;
            exec_clocks <= next_clocks;
            if (next_valid) dec <= cur;
        end
    end

    // timer holds the instruction for its clock count
    opd_timer u_timer (
        .clk(clk),
        .nrst(nrst),
        .en(en),
        .start(start),
        .cycles(next_clocks),
        .busy(tmr_busy),
        .done(tmr_done)
    );

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            exec_busy <= 1'b0;
            exec_done <= 1'b0;
        end else if (en) begin
            exec_busy <= tmr_busy;
            exec_done <= tmr_done;
        end
    end
endmodule : opd_decode
`default_nettype wire

/* File: opd_props.sv */
// checker for the opcode decoder: clock counts charged per decoded op
// assumes one clock domain; bound onto opd_decode below
`timescale 1ns/10ps
`default_nettype none
module opd_props (
    input wire logic clk, // processor clock
    input wire logic nrst, // async reset, active low
    input wire logic data_mem_slow, // long end of a range
    input wire logic [7:0] count_register_low, // shift count
    input wire opd_pkg::opd_decode_t dec, // decoded instruction
    input wire logic dec_valid, // decode pulse
    input wire logic [7:0] exec_clocks // clocks charged
);
    import opd_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // range offsets: a mixed-up slow strobe shows
    wire logic [7:0] slow3 = data_mem_slow ? 8'h03 : 8'h00;
    wire logic [7:0] slow8 = data_mem_slow ? 8'h08 : 8'h00;
    a_seg_load: assert property (dec_valid && dec.op == OPD_SEG_LOAD |->
        exec_clocks == (dec.mem_operand ? 8'h09 : 8'h02)) else $error("segment load count");
    a_xlate_clks: assert property (dec_valid && dec.op == OPD_XLATE |->
        exec_clocks == 8'h0B) else $error("translate count");
    a_flags_acc: assert property (dec_valid && dec.op == OPD_FLAGS_TO_ACC |->
        exec_clocks == 8'h02) else $error("flags copy count");
    a_far_mem: assert property (dec_valid && dec.op inside {OPD_FAR_DATA, OPD_FAR_EXTRA} |->
        dec.mem_operand && exec_clocks == 8'h12) else $error("far pointer load");
    a_divu_clks: assert property (dec_valid && dec.op == OPD_DIV_U |-> exec_clocks ==
        (dec.mem_operand ? (dec.is_word ? 8'h2C : 8'h23) : (dec.is_word ? 8'h26 : 8'h1D)))
        else $error("unsigned divide count");
    a_divs_clks: assert property (dec_valid && dec.op == OPD_DIV_S |-> exec_clocks == slow8 +
        (dec.mem_operand ? (dec.is_word ? 8'h3B : 8'h32) : (dec.is_word ? 8'h35 : 8'h2C)))
        else $error("signed divide count");
    a_muls_clks: assert property (dec_valid && dec.op == OPD_MUL_S |-> exec_clocks == slow3 +
        (dec.mem_operand ? (dec.is_word ? 8'h28 : 8'h1F) : (dec.is_word ? 8'h22 : 8'h19)))
        else $error("signed multiply count");
    a_imm_mul: assert property (dec_valid && dec.op == OPD_IMM_MUL |->
        exec_clocks == slow3 + (dec.mem_operand ? 8'h1D : 8'h16)) else $error("imm multiply");
    a_test_clks: assert property (dec_valid && dec.op == OPD_TEST |->
        exec_clocks == (dec.mem_operand ? 8'h0A : 8'h03)) else $error("test count");
    a_shift_kind: assert property (dec_valid && dec.op == OPD_SHIFT |->
        dec.shift_kind_field != SK_RESERVED) else $error("reserved shift kind");
    a_shift_reg: assert property (dec_valid && dec.op == OPD_SHIFT && !dec.mem_operand |->
        (exec_clocks == 8'h02 || exec_clocks == 8'h05 + count_register_low))
        else $error("register shift count");
    c_divs_slow: cover property (dec_valid && dec.op == OPD_DIV_S && data_mem_slow);
    c_illegal: cover property (dec_valid && dec.op == OPD_ILLEGAL);
    c_shift_mem: cover property (dec_valid && dec.op == OPD_SHIFT && dec.mem_operand);
endmodule : opd_props
bind opd_decode opd_props opd_props_inst (.clk(clk), .nrst(nrst),
    .data_mem_slow(data_mem_slow), .count_register_low(count_register_low),
    .dec(dec), .dec_valid(dec_valid), .exec_clocks(exec_clocks));
`default_nettype wire

/* File: opd_queue_model.sv */
// prefetch queue model: offers queued bytes to the decoder one at a time
// assumes byte_take is the registered pulse after a consumed byte
`timescale 1ns/10ps
`default_nettype none
module opd_queue_model (
    input wire logic clk, // processor clock
    input wire logic byte_take, // decoder consumed the byte
    output logic byte_valid, // byte offered
    output logic [7:0] byte_data // offered byte
);
    logic [7:0] q[$];
    // bench appends instruction bytes
    task automatic push(input logic [7:0] b);
        q.push_back(b);
    endtask : push
    // offer for one cycle, then withdraw; a held byte could be taken twice
    initial begin
        byte_valid = 1'b0;
        byte_data = 8'hA5;
        forever begin
            @(negedge clk);
            if (q.size() != 0) begin
                byte_valid = 1'b1;
                byte_data = q[0];
                @(negedge clk);
                if (byte_take === 1'b1) begin
                    void'(q.pop_front());
                end
                byte_valid = 1'b0;
                byte_data = ~byte_data; // released lines show no stale value
            end
        end
    end
endmodule : opd_queue_model
`default_nettype wire

/* File: tb_cpu_opcode_decode_timing.sv */
// testbench for the opcode decoder: feeds instructions, checks op and clocks
// assumes the queue model and the bound checker; inputs change at negedge
`timescale 1ns/10ps
`default_nettype none
module tb_cpu_opcode_decode_timing;
    import opd_pkg::*;
    logic clk = 1'b0;
    logic nrst, en, slow, byte_valid, byte_take, dec_valid, exec_busy, exec_done;
    logic [7:0] byte_data, cl, exec_clocks;
    opd_decode_t dec;
    int miscompares = 0;
    int cmp_count = 0;
    // 10 MHz processor clock
    always #50 clk = ~clk;
    opd_decode opd_decode_inst (.clk(clk), .nrst(nrst), .en(en), .byte_valid(byte_valid),
        .byte_data(byte_data), .count_register_low(cl), .data_mem_slow(slow),
        .byte_take(byte_take), .dec(dec), .dec_valid(dec_valid), .exec_busy(exec_busy),
        .exec_done(exec_done), .exec_clocks(exec_clocks));
    opd_queue_model opd_queue_model_inst (.clk(clk), .byte_take(byte_take),
        .byte_valid(byte_valid), .byte_data(byte_data));
    // one comparison; an unknown never counts as a match
    task automatic check(input logic ok, input string what);
        cmp_count++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("MISMATCH t=%0t %s", $time, what);
        end
    endtask : check
    // queue one instruction, wait for its decode, then for its last clock
    task automatic run(input logic [31:0] b, input int n, input opd_op_t op,
            input logic [7:0] clks);
        int i;
        for (i = n - 1; i >= 0; i--) opd_queue_model_inst.push(b[8*i +: 8]);
        i = 0;
        while (dec_valid !== 1'b1 && i < 300) begin
            @(negedge clk);
            i++;
        end
        while (exec_done !== 1'b1 && i < 300) begin
            @(negedge clk);
            i++;
        end
        check(i < 300 && dec.op === op && exec_clocks === clks, "op or clock count");
    endtask : run
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test
    // every decoded op once, ranges at both ends
    initial begin
        nrst = 1'b0;
        en = 1'b1;
        slow = 1'b0;
        cl = 8'h03;
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        run(32'h9F, 1, OPD_FLAGS_TO_ACC, 8'h02);
        run(32'h9E, 1, OPD_ACC_TO_FLAGS, 8'h03);
        run(32'h8EC0, 2, OPD_SEG_LOAD, 8'h02);
        run(32'h8E063412, 4, OPD_SEG_LOAD, 8'h09);
        check(dec.disp_bytes === 2'h2 && dec.mem_operand === 1'b1, "direct form");
        run(32'h8C4005, 3, OPD_SEG_STORE, 8'h0B);
        check(dec.disp_bytes === 2'h1, "short displacement");
        run(32'hD7, 1, OPD_XLATE, 8'h0B);
        run(32'h8D9E1020, 4, OPD_LOAD_ADDR, 8'h06);
        check(dec.reg_sel === 3'h3 && dec.rm_sel === 3'h6, "register fields");
        run(32'hC500, 2, OPD_FAR_DATA, 8'h12);
        run(32'hC407, 2, OPD_FAR_EXTRA, 8'h12);
        run(32'hC4C0, 2, OPD_ILLEGAL, 8'h01);
        run(32'h37, 1, OPD_ADJ_ADD, 8'h08);
        run(32'h27, 1, OPD_DEC_ADD, 8'h04);
        run(32'hD40A, 2, OPD_ADJ_MUL, 8'h13);
        run(32'hD50A, 2, OPD_ADJ_DIV, 8'h0F);
        run(32'hD40B, 2, OPD_ILLEGAL, 8'h01);
        run(32'h98, 1, OPD_BYTE_EXT, 8'h02);
        run(32'h99, 1, OPD_WORD_EXT, 8'h04);
        run(32'hF6F0, 2, OPD_DIV_U, 8'h1D);
        run(32'hF7F0, 2, OPD_DIV_U, 8'h26);
        run(32'hF630, 2, OPD_DIV_U, 8'h23);
        run(32'hF730, 2, OPD_DIV_U, 8'h2C);
        run(32'hF6F8, 2, OPD_DIV_S, 8'h2C);
        run(32'hF738, 2, OPD_DIV_S, 8'h3B);
        run(32'hF628, 2, OPD_MUL_S, 8'h1F);
        run(32'h69C03412, 4, OPD_IMM_MUL, 8'h16);
        check(dec.imm_bytes === 2'h2 && dec.is_word === 1'b1, "word immediate");
        run(32'h6B0705, 3, OPD_IMM_MUL, 8'h1D);
        check(dec.imm_bytes === 2'h1, "byte immediate");
        slow = 1'b1;
        run(32'hF7F8, 2, OPD_DIV_S, 8'h3D);
        run(32'hF638, 2, OPD_DIV_S, 8'h3A);
        run(32'hF6E8, 2, OPD_MUL_S, 8'h1C);
        run(32'hF728, 2, OPD_MUL_S, 8'h2B);
        run(32'h6BC0FF, 3, OPD_IMM_MUL, 8'h19);
        slow = 1'b0;
        for (int k = 0; k < 8; k++) begin
            run({16'h0000, 8'hD1, 2'h3, k[2:0], 3'h0}, 2, (k == 6) ? OPD_ILLEGAL : OPD_SHIFT,
                (k == 6) ? 8'h01 : 8'h02);
            check(k == 6 || dec.shift_kind_field === opd_shift_t'(k[2:0]), "kind");
        end
        run(32'hD007, 2, OPD_SHIFT, 8'h0F);
        run(32'hD3E8, 2, OPD_SHIFT, 8'h08);
        run(32'hD207, 2, OPD_SHIFT, 8'h14);
        run(32'hC1E803, 3, OPD_SHIFT, 8'h08);
        run(32'h85C0, 2, OPD_TEST, 8'h03);
        run(32'h8407, 2, OPD_TEST, 8'h0A);
        run(32'h6C, 1, OPD_PORT_IN, 8'h0E);
        run(32'h6F, 1, OPD_PORT_OUT, 8'h0E);
        run(32'hAC, 1, OPD_STR_LOAD, 8'h0C);
        run(32'hAB, 1, OPD_STR_STORE, 8'h0A);
        end_of_test();
    end
    // watchdog: the tests need under two thousand cycles
    initial begin
        #3000000;
        miscompares++;
        end_of_test();
    end
endmodule : tb_cpu_opcode_decode_timing
`default_nettype wire
